// file: rtl/pcg_pkg.sv
// Package: register map, field positions and reset values of the clock-gate and event-enable block
package pcg_pkg;
  // Byte addresses of the registers
  localparam logic [7:0] PCG_OFF_CLK_GATE   = 8'h48;
  localparam logic [7:0] PCG_OFF_EVENT_EN   = 8'h4c;
  localparam logic [7:0] PCG_OFF_IRQ_STATUS = 8'h60;
  localparam logic [7:0] PCG_OFF_IRQ_MASK   = 8'h64;

  // Clock-gate field positions
  localparam int PCG_BIT_THIRD_SERIAL = 1;
  localparam int PCG_BIT_RNG          = 2;
  localparam int PCG_BIT_SEC_FLASH    = 3;
  localparam int PCG_BIT_EXT_MEM      = 4;
  localparam int PCG_BIT_PORT_FOUR    = 6;
  localparam int PCG_BIT_SYS_CACHE    = 7;
  localparam int PCG_BIT_DMA          = 8;
  localparam int PCG_BIT_SEMAPHORE    = 9;
  localparam int PCG_BIT_SD_HOST      = 10;
  localparam int PCG_NUM_GATES        = 11;

  // Writable gating bits: 10..6 and 4..1; bits 5 and 0 are reserved
  localparam logic [31:0] PCG_GATE_WMASK  = 32'h0000_07de;
  localparam logic [31:0] PCG_GATE_RESET  = 32'h0000_0000;

  // Event-enable field positions
  localparam int PCG_BIT_DMA_WAKE = 0;
  localparam int PCG_BIT_RX_EVENT = 1;
  localparam int PCG_BIT_TX_EVENT = 2;
  localparam logic [31:0] PCG_EVT_WMASK = 32'h0000_0007;
  localparam logic [31:0] PCG_EVT_RESET = 32'h0000_0000;

  // Interrupt status bits: 0 blocked access, 1 send event seen, 2 dma wake
  localparam int PCG_IRQ_BLOCKED  = 0;
  localparam int PCG_IRQ_SENT     = 1;
  localparam int PCG_IRQ_DMA_WAKE = 2;
  localparam logic [31:0] PCG_IRQ_WMASK = 32'h0000_0007;
  localparam logic [31:0] PCG_IRQ_RESET = 32'h0000_0000;

  localparam logic [1:0] PCG_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PCG_RESP_SLVERR = 2'b10;
endpackage

// file: rtl/pcg_event_router.sv
// Event router: send-event pulse out, wake-event merge into core
`timescale 1ns/1ps
`default_nettype none
module pcg_event_router
  import pcg_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Enables
  input  wire logic [2:0] event_en,
  // Event sources
  input  wire logic       send_event_instruction,
  input  wire logic       dma_count_to_zero,
  input  wire logic       ext_receive_event,
  // Event outputs
  output var  logic       send_event_pin,
  output var  logic       receive_event_line,
  output var  logic       sent_evt,
  output var  logic       dma_wake_evt
);
  wire logic tx_next;
  wire logic rx_next;
  wire logic dma_next;

  // One pulse per instruction strobe, only while enabled
  assign tx_next  = event_en[PCG_BIT_TX_EVENT] & send_event_instruction;
  // Disabled wake sources are simply dropped, never latched for later
  assign dma_next = event_en[PCG_BIT_DMA_WAKE] & dma_count_to_zero;
  assign rx_next  = dma_next | (event_en[PCG_BIT_RX_EVENT] & ext_receive_event);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      send_event_pin     <= 1'b0;
      receive_event_line <= 1'b0;
      sent_evt           <= 1'b0;
      dma_wake_evt       <= 1'b0;
    end else begin
      send_event_pin     <= tx_next;
      receive_event_line <= rx_next;
      sent_evt           <= tx_next;
      dma_wake_evt       <= dma_next;
    end
  end
endmodule // pcg_event_router
`default_nettype wire

// file: rtl/pcg_top.sv
// Peripheral clock-gate and core event-enable block with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
(
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]               s_axi_bresp,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0]              s_axi_rdata,
  output var  logic [1:0]               s_axi_rresp,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Peripheral clock control and access blocking
  output var  logic [PCG_NUM_GATES-1:0] periph_clk_en,
  output var  logic [PCG_NUM_GATES-1:0] periph_access_block,
  input  wire logic [PCG_NUM_GATES-1:0] periph_access_req,
  // Core events
  input  wire logic                     send_event_instruction,
  input  wire logic                     dma_count_to_zero,
  input  wire logic                     ext_receive_event,
  output var  logic                     send_event_pin,
  output var  logic                     receive_event_line,
  // Interrupt
  output var  logic                     irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] gate_reg;
  logic [31:0] evt_reg;
  logic [31:0] sts_reg;
  logic [31:0] msk_reg;
  logic [7:0]  awaddr_reg;
  logic        aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_held_reg;

  wire logic [31:0] gate_next;
  wire logic [31:0] evt_next;
  wire logic [31:0] sts_next;
  wire logic [31:0] msk_next;

  // Merge a write under byte strobes and a mask of writable bits
  function automatic logic [31:0] pcg_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    pcg_merge = (old_v & ~(lane & wmask)) | (new_v & lane & wmask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order

  wire logic       aw_take;
  wire logic       w_take;
  wire logic       aw_have;
  wire logic       w_have;
  wire logic [7:0] wr_addr;
  wire logic [31:0] wr_data;
  wire logic [3:0] wr_strb;
  wire logic       wr_fire;
  wire logic       wr_gate_hit;
  wire logic       wr_evt_hit;
  wire logic       wr_sts_hit;
  wire logic       wr_msk_hit;
  wire logic       wr_mapped;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign aw_have = aw_held_reg | aw_take;
  assign w_have  = w_held_reg | w_take;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_fire = aw_have & w_have & ~s_axi_bvalid;

  assign wr_gate_hit = wr_fire & (wr_addr[7:2] == PCG_OFF_CLK_GATE[7:2]);
  assign wr_evt_hit  = wr_fire & (wr_addr[7:2] == PCG_OFF_EVENT_EN[7:2]);
  assign wr_sts_hit  = wr_fire & (wr_addr[7:2] == PCG_OFF_IRQ_STATUS[7:2]);
  assign wr_msk_hit  = wr_fire & (wr_addr[7:2] == PCG_OFF_IRQ_MASK[7:2]);
  assign wr_mapped   = wr_gate_hit | wr_evt_hit | wr_sts_hit | wr_msk_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      // Ready only while that half is not yet held and no response pends
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready  <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_held_reg <= aw_have & ~wr_fire;
      w_held_reg  <= w_have & ~wr_fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PCG_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates

  // Reserved bits are not writable, so stray software writes cannot disturb them
  assign gate_next = wr_gate_hit ? pcg_merge(gate_reg, wr_data, wr_strb, PCG_GATE_WMASK)
                                 : gate_reg;
  assign evt_next  = wr_evt_hit ? pcg_merge(evt_reg, wr_data, wr_strb, PCG_EVT_WMASK)
                                : evt_reg;
  assign msk_next  = wr_msk_hit ? pcg_merge(msk_reg, wr_data, wr_strb, PCG_IRQ_WMASK)
                                : msk_reg;

  // Interrupt events
  wire logic       sent_evt;
  wire logic       dma_wake_evt;
  wire logic       blocked_evt;
  wire logic [31:0] sts_set;
  wire logic [31:0] sts_clr;

  assign blocked_evt = |(periph_access_req & periph_access_block);
  assign sts_set = {29'h0000_0000, dma_wake_evt, sent_evt, blocked_evt};
  assign sts_clr = wr_sts_hit ? pcg_merge(32'h0000_0000, wr_data, wr_strb, PCG_IRQ_WMASK)
                              : 32'h0000_0000;
  // Set wins over a same-cycle write-one clear
  assign sts_next = (sts_reg & ~sts_clr) | sts_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_reg <= PCG_GATE_RESET;
      evt_reg  <= PCG_EVT_RESET;
      sts_reg  <= PCG_IRQ_RESET;
      msk_reg  <= PCG_IRQ_RESET;
    end else begin
      gate_reg <= gate_next;
      evt_reg  <= evt_next;
      sts_reg  <= sts_next;
      msk_reg  <= msk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_clk_en       <= {PCG_NUM_GATES{1'b1}};
      periph_access_block <= {PCG_NUM_GATES{1'b0}};
      irq                 <= 1'b0;
    end else begin
      // One in a gating bit turns the enable off
      periph_clk_en       <= ~gate_next[PCG_NUM_GATES-1:0];
      // Gating stops the clock and blocks access, never resets the peripheral
      periph_access_block <= gate_next[PCG_NUM_GATES-1:0] & PCG_GATE_WMASK[PCG_NUM_GATES-1:0];
      irq                 <= |(sts_next & msk_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event routing

  pcg_event_router u_router (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .event_en               (evt_reg[2:0]),
    .send_event_instruction (send_event_instruction),
    .dma_count_to_zero      (dma_count_to_zero),
    .ext_receive_event      (ext_receive_event),
    .send_event_pin         (send_event_pin),
    .receive_event_line     (receive_event_line),
    .sent_evt               (sent_evt),
    .dma_wake_evt           (dma_wake_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  wire logic        ar_take;
  wire logic [31:0] rd_val;
  wire logic        rd_mapped;

  assign ar_take   = s_axi_arvalid & s_axi_arready;
  assign rd_mapped = (s_axi_araddr[7:2] == PCG_OFF_CLK_GATE[7:2]) |
                     (s_axi_araddr[7:2] == PCG_OFF_EVENT_EN[7:2]) |
                     (s_axi_araddr[7:2] == PCG_OFF_IRQ_STATUS[7:2]) |
                     (s_axi_araddr[7:2] == PCG_OFF_IRQ_MASK[7:2]);
  assign rd_val = (s_axi_araddr[7:2] == PCG_OFF_CLK_GATE[7:2])   ? gate_reg :
                  (s_axi_araddr[7:2] == PCG_OFF_EVENT_EN[7:2])   ? evt_reg  :
                  (s_axi_araddr[7:2] == PCG_OFF_IRQ_STATUS[7:2]) ? sts_reg  :
                  (s_axi_araddr[7:2] == PCG_OFF_IRQ_MASK[7:2])   ? msk_reg  : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PCG_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_mapped ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pcg_top
`default_nettype wire

// file: testbench/pcg_top_monitor.sv
// Port-level assertions for the clock-gate and event-enable block
`timescale 1ns/1ps
`default_nettype none
module pcg_monitor
  import pcg_pkg::*;
(
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Bus handshakes
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  // Gating and events
  input wire logic [PCG_NUM_GATES-1:0] periph_clk_en,
  input wire logic [PCG_NUM_GATES-1:0] periph_access_block,
  input wire logic                     send_event_instruction,
  input wire logic                     dma_count_to_zero,
  input wire logic                     ext_receive_event,
  input wire logic                     send_event_pin,
  input wire logic                     receive_event_line,
  input wire logic                     irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  rst_values_a: assert property ($rose(aresetn) |-> periph_clk_en == '1 && periph_access_block == '0 && !irq)
    else $error("outputs not at reset values after release");
  gate_split_a: assert property (periph_clk_en == ~periph_access_block)
    else $error("clock enable and access block disagree");
  // Gating may only move as a write completes
  gate_change_a: assert property ($changed(periph_clk_en) |-> $rose(s_axi_bvalid))
    else $error("clock enable changed outside a write");
  send_pulse_a: assert property (send_event_pin |-> $past(send_event_instruction))
    else $error("send event pin without instruction");
  wake_src_a: assert property (receive_event_line |-> $past(dma_count_to_zero || ext_receive_event))
    else $error("wake line without a source event");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  pin_cover: cover property (send_event_pin);
  wake_cover: cover property (receive_event_line);
  irq_cover: cover property (irq);
endmodule // pcg_monitor
bind pcg_top pcg_monitor mon_u (.*);
`default_nettype wire

// file: testbench/test_pcg_top.sv
// Self-checking bench for the clock-gate and event-enable block
`timescale 1ns/1ps
`default_nettype none
module test_pcg_top
  import pcg_pkg::*;
;
  logic                     aclk = 1'b0;
  logic                     aresetn = 1'b0;
  logic [7:0]               s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]               s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0]              s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]               s_axi_wstrb = 4'hf;
  logic                     s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                     s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]               s_axi_bresp, s_axi_rresp, rsp;
  logic [PCG_NUM_GATES-1:0] periph_clk_en, periph_access_block;
  logic [PCG_NUM_GATES-1:0] periph_access_req = '0;
  logic                     send_event_instruction = 1'b0, dma_count_to_zero = 1'b0, ext_receive_event = 1'b0;
  logic                     send_event_pin, receive_event_line, irq;
  int                       num_errors = 0, checked = 0, cycles = 0;

  always #4 aclk = ~aclk;
  pcg_top dut_u (.*);
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Response ready rises with the request and stays up until the answer is sampled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    axi_rd(a);
    check(what, rd, exp);
  endtask

  task automatic pulse(input logic [2:0] src, input logic ep, input logic el);
    @(posedge aclk);
    {send_event_instruction, dma_count_to_zero, ext_receive_event} <= src;
    @(posedge aclk);
    {send_event_instruction, dma_count_to_zero, ext_receive_event} <= 3'h0;
    #1;
    check("send_event_pin", 32'(send_event_pin), 32'(ep));
    check("receive_event_line", 32'(receive_event_line), 32'(el));
    @(posedge aclk);
    #1;
    check("pin_width", 32'(send_event_pin), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    #1;
    check("clk_en_rst", 32'(periph_clk_en), 32'h0000_07ff);
    rd_chk(PCG_OFF_CLK_GATE, 32'h0, "gate_rst");
    rd_chk(PCG_OFF_EVENT_EN, 32'h0, "event_rst");
  endtask

  task automatic t_unmapped;
    axi_wr(8'h70, 32'hffff_ffff);
    check("bresp_unmapped", 32'(rsp), 32'(PCG_RESP_SLVERR));
    axi_rd(8'h70);
    check("rresp_unmapped", 32'(rsp), 32'(PCG_RESP_SLVERR));
    check("rdata_unmapped", rd, 32'h0);
  endtask

  task automatic t_gating;
    int gb[9] = '{1, 2, 3, 4, 6, 7, 8, 9, 10};
    logic [31:0] one;
    axi_wr(PCG_OFF_EVENT_EN, 32'h0000_0004);
    foreach (gb[i]) begin
      one = 32'h1 << gb[i];
      axi_wr(PCG_OFF_CLK_GATE, one);
      #1;
      check("clk_en", 32'(periph_clk_en), ~one & 32'h0000_07ff);
      check("block", 32'(periph_access_block), one);
      rd_chk(PCG_OFF_CLK_GATE, one, "gate_rb");
    end
    // Reserved bits are written back as zero, never set by the bench
    axi_wr(PCG_OFF_CLK_GATE, 32'h0000_07de);
    rd_chk(PCG_OFF_CLK_GATE, 32'h0000_07de, "gate_resv");
    axi_wr(PCG_OFF_CLK_GATE, 32'h0, 4'h1);
    rd_chk(PCG_OFF_CLK_GATE, 32'h0000_0700, "gate_strb");
    rd_chk(PCG_OFF_EVENT_EN, 32'h0000_0004, "event_kept");
    axi_wr(PCG_OFF_EVENT_EN, 32'h0000_0007);
    rd_chk(PCG_OFF_EVENT_EN, 32'h0000_0007, "event_resv");
  endtask

  task automatic t_block;
    @(posedge aclk);
    periph_access_req <= 11'h004;
    @(posedge aclk);
    periph_access_req <= 11'h100;
    @(posedge aclk);
    periph_access_req <= 11'h000;
    rd_chk(PCG_OFF_IRQ_STATUS, 32'h1, "stat_blocked");
    check("irq_masked", 32'(irq), 32'h0);
    axi_wr(PCG_OFF_IRQ_MASK, 32'h1);
    @(posedge aclk);
    #1;
    check("irq_on", 32'(irq), 32'h1);
    axi_wr(PCG_OFF_IRQ_STATUS, 32'h1);
    @(posedge aclk);
    #1;
    check("irq_off", 32'(irq), 32'h0);
    axi_wr(PCG_OFF_CLK_GATE, 32'h0);
  endtask

  task automatic t_events;
    axi_wr(PCG_OFF_EVENT_EN, 32'h0);
    pulse(3'h4, 1'b0, 1'b0);
    pulse(3'h2, 1'b0, 1'b0);
    pulse(3'h1, 1'b0, 1'b0);
    axi_wr(PCG_OFF_EVENT_EN, 32'h7);
    pulse(3'h4, 1'b1, 1'b0);
    pulse(3'h2, 1'b0, 1'b1);
    pulse(3'h1, 1'b0, 1'b1);
    axi_wr(PCG_OFF_EVENT_EN, 32'h2);
    pulse(3'h2, 1'b0, 1'b0);
    rd_chk(PCG_OFF_IRQ_STATUS, 32'h6, "stat_events");
  endtask

  // A reset in mid-run must bring every gate back to running
  task automatic t_rerun;
    axi_wr(PCG_OFF_CLK_GATE, 32'h0000_0042);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    check("clk_en_rerun", 32'(periph_clk_en), 32'h0000_07ff);
    rd_chk(PCG_OFF_CLK_GATE, 32'h0, "gate_rerun");
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_gating();
    t_block();
    t_events();
    t_rerun();
    stop_test();
  end
endmodule // test_pcg_top
`default_nettype wire
